// [design/mcsw_consts.svh]
// bit positions, widths and reset values of the card status word
`ifndef MCSW_CONSTS_SVH
`define MCSW_CONSTS_SVH

`define MCSW_WORD_W 17
`define MCSW_BIT_ID_REWRITE 16
`define MCSW_BIT_WP_SKIP 15
`define MCSW_BIT_ECC_OFF 14
`define MCSW_BIT_ERASE_CANCEL 13
`define MCSW_STATE_HI 12
`define MCSW_STATE_LO 9
`define MCSW_BIT_READY_DATA 8
`define MCSW_BIT_APPLICATION_COMMAND_FLAG 5
`define MCSW_BIT_KEY_ORDER 3
`define MCSW_STATE_LAST 4'h8
`define MCSW_WORD_RST 17'h00000
`define MCSW_STATE_RST 4'h0

`endif

// [design/mcsw_pkg.sv]
// types shared by the card status word design
package mcsw_pkg;

    // card state codes as reported in the status word
    typedef enum logic [3:0] {
        MCSW_ST_IDLE  = 4'b0000,
        MCSW_ST_READY = 4'b0001,
        MCSW_ST_IDENT = 4'b0010,
        MCSW_ST_STBY  = 4'b0011,
        MCSW_ST_TRAN  = 4'b0100,
        MCSW_ST_DATA  = 4'b0101,
        MCSW_ST_RCV   = 4'b0110,
        MCSW_ST_PRG   = 4'b0111,
        MCSW_ST_DIS   = 4'b1000
    } mcsw_state_e;

    typedef logic [16:0] mcsw_word_t;

endpackage : mcsw_pkg

// [design/mcsw_state_track.sv]
// holds the card state that the next response reports
`timescale 1ns/10ps
`include "mcsw_consts.svh"

module mcsw_state_track import mcsw_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // state update from the command engine
    input wire logic state_load,
    input wire logic [3:0] new_state,
    // state as held now
    output mcsw_state_e state_r
);

    mcsw_state_e state_nxt;

    // ---------------------------------------------------------------
    // state register
    // ---------------------------------------------------------------
    // legal codes only
    // reserved codes 9..15 are refused so the field never shows them
    always_comb begin
        state_nxt = state_r;
        if (state_load && (new_state <= `MCSW_STATE_LAST)) begin
            state_nxt = mcsw_state_e'(new_state);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= MCSW_ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

endmodule : mcsw_state_track

// [design/mcsw_status_word.sv]
// card status word, bits 16 down to 3, built per received command
//
// Function
// - set bit 16 on identity rewrite, config mismatch or protect reversal
// - set bit 15 when erase skipped write-protected blocks
// - bit 14 high when command ran without internal correction
// - set bit 13 when pending erase sequence was cancelled
// - bits 12..9 carry card state code, 0..8, reserved 9..15
// - state change by a command shows only in next response
// - bit 8 follows buffer empty, ready for data
// - bit 5 shows application command expected or interpreted
// - set bit 3 on key exchange order error
`timescale 1ns/10ps
`include "mcsw_consts.svh"

module mcsw_status_word import mcsw_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // command receipt strobe, one cycle
    input wire logic cmd_rx,
    // error and notice events, one-cycle pulses
    input wire logic ev_identity_rewrite,
    input wire logic ev_config_mismatch,
    input wire logic ev_protect_reverse,
    input wire logic ev_erase_wp_skip,
    input wire logic ev_erase_cancel,
    input wire logic ev_key_order,
    // live status levels
    input wire logic ecc_disabled,
    input wire logic buffer_empty,
    input wire logic application_command_flag,
    // state update from the command engine
    input wire logic state_load,
    input wire logic [3:0] new_state,
    // response status word
    output mcsw_word_t resp_status_r,
    output logic resp_valid_r
);

    // ---------------------------------------------------------------
    // sticky flags
    // ---------------------------------------------------------------
    logic id_rewrite_r, id_rewrite_nxt;
    logic wp_skip_r, wp_skip_nxt;
    logic erase_cancel_r, erase_cancel_nxt;
    logic key_order_r, key_order_nxt;
    mcsw_word_t resp_status_nxt;
    logic resp_valid_nxt;
    mcsw_state_e state_r;
    logic id_event;

    // a flag cleared by a response still takes an event of that cycle
    function automatic logic sticky_next(input logic cur, input logic ev,
                                         input logic clr);
        sticky_next = (cur & ~clr) | ev;
    endfunction : sticky_next

    assign id_event = ev_identity_rewrite | ev_config_mismatch |
                      ev_protect_reverse;

    // set wins over the clear that the response brings
    // such an event shows in this response and again in the next one;
    // a repeat is safer than losing an error that lands on the clear
    always_comb begin
        id_rewrite_nxt = sticky_next(id_rewrite_r, id_event, cmd_rx);
        wp_skip_nxt = sticky_next(wp_skip_r, ev_erase_wp_skip, cmd_rx);
        erase_cancel_nxt = sticky_next(erase_cancel_r, ev_erase_cancel,
                                       cmd_rx);
        key_order_nxt = sticky_next(key_order_r, ev_key_order, cmd_rx);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            id_rewrite_r <= 1'b0;
            wp_skip_r <= 1'b0;
            erase_cancel_r <= 1'b0;
            key_order_r <= 1'b0;
        end else begin
            id_rewrite_r <= id_rewrite_nxt;
            wp_skip_r <= wp_skip_nxt;
            erase_cancel_r <= erase_cancel_nxt;
            key_order_r <= key_order_nxt;
        end
    end

    // ---------------------------------------------------------------
    // card state
    // ---------------------------------------------------------------
    mcsw_state_track u_state (
        .clk(clk),
        .rst_n(rst_n),
        .state_load(state_load),
        .new_state(new_state),
        .state_r(state_r)
    );

    // ---------------------------------------------------------------
    // response word
    // ---------------------------------------------------------------
    // word is captured at command receipt and held until the next one
    // levels are seen only in the receipt cycle, pulses between are kept by the sticky flags
    always_comb begin
        resp_status_nxt = resp_status_r;
        resp_valid_nxt = cmd_rx;
        if (cmd_rx) begin
            resp_status_nxt = `MCSW_WORD_RST;
            resp_status_nxt[`MCSW_BIT_ID_REWRITE] = id_rewrite_r | id_event;
            resp_status_nxt[`MCSW_BIT_WP_SKIP] = wp_skip_r |
                                                 ev_erase_wp_skip;
            resp_status_nxt[`MCSW_BIT_ECC_OFF] = ecc_disabled;
            resp_status_nxt[`MCSW_BIT_ERASE_CANCEL] = erase_cancel_r |
                                                      ev_erase_cancel;
            // registered state, an update in this cycle waits
            resp_status_nxt[`MCSW_STATE_HI:`MCSW_STATE_LO] = state_r;
            resp_status_nxt[`MCSW_BIT_READY_DATA] = buffer_empty;
            resp_status_nxt[`MCSW_BIT_APPLICATION_COMMAND_FLAG] = application_command_flag;
            resp_status_nxt[`MCSW_BIT_KEY_ORDER] = key_order_r |
                                                   ev_key_order;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            resp_status_r <= `MCSW_WORD_RST;
            resp_valid_r <= 1'b0;
        end else begin
            resp_status_r <= resp_status_nxt;
            resp_valid_r <= resp_valid_nxt;
        end
    end

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    // all checks run on the card clock, off while reset is low
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_id_rewrite_set: assert property (
        (ev_identity_rewrite || ev_config_mismatch || ev_protect_reverse)
        && !cmd_rx ##1 cmd_rx |=> resp_status_r[16])
        else $error("overwrite error lost before response");
    // clears are seen only with two commands in a row
    a_id_rewrite_clr: assert property (
        cmd_rx ##1 (cmd_rx && !id_event && !$past(id_event))
        |=> !resp_status_r[16])
        else $error("overwrite error not cleared");
    a_wp_skip_bit: assert property (
        cmd_rx |=> resp_status_r[15] ==
        ($past(wp_skip_r) || $past(ev_erase_wp_skip)))
        else $error("erase skip bit wrong");
    a_wp_skip_clr: assert property (
        cmd_rx ##1 (cmd_rx && !ev_erase_wp_skip && !$past(ev_erase_wp_skip))
        |=> !resp_status_r[15])
        else $error("erase skip bit not cleared");
    a_ecc_off_bit: assert property (
        cmd_rx |=> resp_status_r[14] == $past(ecc_disabled))
        else $error("correction off bit wrong");
    a_erase_cancel_set: assert property (
        ev_erase_cancel && cmd_rx |=> resp_status_r[13] && resp_valid_r)
        else $error("erase cancel not reported");
    a_erase_cancel_clr: assert property (
        cmd_rx ##1 (cmd_rx && !ev_erase_cancel && !$past(ev_erase_cancel))
        |=> !resp_status_r[13])
        else $error("erase cancel bit not cleared");
    a_state_legal: assert property (
        resp_status_r[12:9] <= `MCSW_STATE_LAST)
        else $error("reserved state code reported");
    a_state_refused: assert property (
        state_load && (new_state > `MCSW_STATE_LAST) |=> $stable(state_r))
        else $error("reserved state code taken");
    a_state_delayed: assert property (
        cmd_rx && state_load && (new_state <= `MCSW_STATE_LAST)
        ##1 cmd_rx |=> resp_status_r[12:9] == $past(new_state, 2))
        else $error("state change not in next response");
    a_valid_follow: assert property (
        cmd_rx |=> resp_valid_r)
        else $error("response valid missing");
    a_word_hold: assert property (
        !cmd_rx |=> $stable(resp_status_r) && !resp_valid_r)
        else $error("response word moved without command");
    a_ready_data_bit: assert property (
        cmd_rx |=> resp_status_r[8] == $past(buffer_empty))
        else $error("ready for data bit wrong");
    a_application_command_flag_bit: assert property (
        cmd_rx |=> resp_status_r[5] == $past(application_command_flag))
        else $error("application command bit wrong");
    a_key_order_clr: assert property (
        cmd_rx ##1 (cmd_rx && !ev_key_order && !$past(ev_key_order))
        |=> !resp_status_r[3])
        else $error("key order error not cleared");
    a_key_order_set: assert property (
        (ev_key_order && !cmd_rx) ##1 cmd_rx |=> resp_status_r[3])
        else $error("key order error lost before response");
    a_reserved_zero: assert property (
        resp_status_r[7:6] == 2'h0 && resp_status_r[4] == 1'b0 &&
        resp_status_r[2:0] == 3'h0)
        else $error("reserved bit not zero");

    c_id_rewrite: cover property (ev_config_mismatch ##1 cmd_rx);
    c_state_move: cover property (state_load ##1 cmd_rx ##1 cmd_rx);
    c_set_and_clear: cover property (ev_key_order && cmd_rx);
    // main scenarios reached
    c_back_to_back: cover property (cmd_rx ##1 cmd_rx ##1 cmd_rx);
    c_early_event: cover property ((ev_erase_cancel && !cmd_rx) ##1 cmd_rx);

endmodule : mcsw_status_word

// [testbench/mcsw_host_model.sv]
// host side model issuing commands and capturing card responses
`timescale 1ns/10ps

module mcsw_host_model import mcsw_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // command request from the bench
    input wire logic send,
    output logic cmd_rx,
    // response from the card
    input wire mcsw_word_t resp_status_r,
    input wire logic resp_valid_r,
    output mcsw_word_t last_word
);
    // strobe passes straight through, one cycle per request
    assign cmd_rx = send;

    // keep the latest word, so a late or missing valid shows up
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            last_word <= '0;
        end else if (resp_valid_r) begin
            last_word <= resp_status_r;
        end
    end
endmodule : mcsw_host_model

// [testbench/memory_card_status_word_tb_top.sv]
// self-checking bench for the card status word
`timescale 1ns/10ps

module memory_card_status_word_tb_top import mcsw_pkg::*;;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic send = 1'b0;
    logic cmd_rx;
    logic [5:0] evs = 6'h00;
    logic [2:0] lv = 3'h0;
    logic state_load = 1'b0;
    logic [3:0] new_state = 4'h0;
    mcsw_word_t resp_status_r;
    mcsw_word_t last_word;
    logic resp_valid_r;
    logic [3:0] st_exp = 4'h0;
    logic [5:0] carry = 6'h00;
    int fail_count = 0;
    int samples_checked = 0;
    int cycles = 0;

    always #4 clk = ~clk;

    mcsw_status_word dut (.clk(clk), .rst_n(rst_n), .cmd_rx(cmd_rx),
        .ev_identity_rewrite(evs[5]), .ev_config_mismatch(evs[4]),
        .ev_protect_reverse(evs[3]), .ev_erase_wp_skip(evs[2]),
        .ev_erase_cancel(evs[1]), .ev_key_order(evs[0]),
        .ecc_disabled(lv[2]), .buffer_empty(lv[1]),
        .application_command_flag(lv[0]), .state_load(state_load),
        .new_state(new_state), .resp_status_r(resp_status_r),
        .resp_valid_r(resp_valid_r));

    mcsw_host_model host (.clk(clk), .rst_n(rst_n), .send(send),
        .cmd_rx(cmd_rx), .resp_status_r(resp_status_r),
        .resp_valid_r(resp_valid_r), .last_word(last_word));

    task automatic chk(input string nm, input logic [16:0] got, exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic final_report();
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : final_report

    // one command; events either in the command cycle or one before
    task automatic cmd(input logic [5:0] ev, input logic [2:0] l,
                       input logic ld, input logic [3:0] ns, input logic early);
        logic [16:0] e;
        logic [5:0] x;
        // sticky bits also carry an event that met the previous response
        x = ev | carry;
        e = {|x[5:3], x[2], l[2], x[1], st_exp, l[1], 2'b00, l[0], 1'b0,
             x[0], 3'b000};
        @(posedge clk);
        evs <= ev;
        if (early) begin
            @(posedge clk);
            evs <= 6'h00;
        end
        lv <= l;
        state_load <= ld;
        new_state <= ns;
        send <= 1'b1;
        @(posedge clk);
        evs <= 6'h00;
        state_load <= 1'b0;
        send <= 1'b0;
        #1;
        chk("resp_valid_r", 17'(resp_valid_r), 17'h00001); // timing
        chk("resp_status_r", resp_status_r, e); // whole word
        if (ld && ns <= 4'h8) st_exp = ns;
        carry = early ? 6'h00 : ev;
        @(posedge clk);
        #1;
        chk("valid_pulse", 17'(resp_valid_r), 17'h00000); // one cycle
        chk("last_word", last_word, e); // word holds
    endtask : cmd

    // cycle ceiling for a hung run
    always @(posedge clk) begin
        cycles++;
        if (cycles > 1500) begin
            fail_count++;
            final_report();
        end
    end

    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        chk("reset_word", resp_status_r, 17'h00000); // reset zero
        // each event alone, in the command cycle (shown twice) or before it
        for (int j = 0; j < 12; j++) begin
            cmd(6'h01 << (j % 6), 3'h0, 1'b0, 4'h0, 1'(j / 6));
            cmd(6'h00, 3'h0, 1'b0, 4'h0, 1'b0); // cleared after an early event, shown again after an in-cycle one
        end
        // all level combinations
        for (int k = 0; k < 8; k++) begin
            cmd(6'h3f, 3'(k), 1'b0, 4'h0, 1'b0);
        end
        // every state code, reserved codes ignored
        for (int s = 0; s < 16; s++) begin
            cmd(6'h00, 3'h2, 1'b1, 4'(s), 1'b0);
        end
        cmd(6'h00, 3'h0, 1'b0, 4'h0, 1'b0); // reserved kept
        // three commands back to back, a state load in the first
        @(posedge clk);
        state_load <= 1'b1;
        new_state <= 4'h4;
        send <= 1'b1;
        @(posedge clk);
        state_load <= 1'b0;
        #1;
        chk("b2b_first", resp_status_r, {4'h0, st_exp, 9'h000});
        @(posedge clk);
        #1;
        chk("b2b_second", resp_status_r, {4'h0, 4'h4, 9'h000});
        @(posedge clk);
        send <= 1'b0;
        #1;
        chk("b2b_third", resp_status_r, {4'h0, 4'h4, 9'h000});
        chk("b2b_valid", 17'(resp_valid_r), 17'h00001);
        final_report();
    end
endmodule : memory_card_status_word_tb_top
